//--- inc/bdcr_cfg.svh
`ifndef BDCR_CFG_SVH
`define BDCR_CFG_SVH

// --------------------------------------------------------------------------
// configuration offsets
// --------------------------------------------------------------------------
`define BDCR_ADDR_W            8
`define BDCR_UBT_OFFSET        8'hc0
`define BDCR_DIAG_OFFSET       8'hc4

// --------------------------------------------------------------------------
// upstream buffer threshold byte fields
// --------------------------------------------------------------------------
`define BDCR_UBT_W             8
`define BDCR_UBT_RESET         8'h00
`define BDCR_UBT_WMASK         8'h3e
`define BDCR_UBT_SEL_HI        5
`define BDCR_UBT_SEL_LO        4
`define BDCR_UBT_EN_BIT        3
`define BDCR_UBT_CFGMEM_BIT    2
`define BDCR_THR_SEL_CL4       2'h0
`define BDCR_THR_SEL_CL8       2'h1
`define BDCR_THR_SEL_CL12      2'h2
`define BDCR_THR_SEL_2CL4      2'h3
`define BDCR_THR_ADD_4         10'h004
`define BDCR_THR_ADD_8         10'h008
`define BDCR_THR_ADD_12        10'h00c
`define BDCR_CL_DEFAULT_DW     8'h08

// --------------------------------------------------------------------------
// diagnostic register fields
// --------------------------------------------------------------------------
`define BDCR_DIAG_W            21
`define BDCR_DIAG_RESET        21'h120108
`define BDCR_DIAG_UPPER_ZERO   11'h000
`define BDCR_L1_SEP_HI         20
`define BDCR_L1_SEP_LO         18
`define BDCR_L1_SHR_HI         17
`define BDCR_L1_SHR_LO         15
`define BDCR_SECONDARY_BUS_RESET_BIT_SUP_BIT      10
`define BDCR_L1_TMR_HI         9
`define BDCR_L1_TMR_LO         6
`define BDCR_L0S_TMR_HI        5
`define BDCR_L0S_TMR_LO        2

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define BDCR_CLK_PERIOD_NS     10
`define BDCR_CLK_KHZ           100000
`define BDCR_L1_TICK_NS        512
`define BDCR_L0S_TICK_KHZ      62500
`define BDCR_L1_TICK_CYC  ((`BDCR_L1_TICK_NS + `BDCR_CLK_PERIOD_NS - 1) / `BDCR_CLK_PERIOD_NS)
`define BDCR_L0S_TICK_CYC ((`BDCR_CLK_KHZ + `BDCR_L0S_TICK_KHZ - 1) / `BDCR_L0S_TICK_KHZ)

`endif

//--- inc/bdcr_pkg.sv
`default_nettype none
package bdcr_pkg;
  typedef logic [31:0] bdcr_word_t;
  typedef logic [9:0]  bdcr_thr_t;
  typedef logic [3:0]  bdcr_tmr_t;
  typedef logic [7:0]  bdcr_fts_t;
endpackage
`default_nettype wire

//--- design/bdcr_idle_timer.sv
`include "bdcr_cfg.svh"
`default_nettype none
module bdcr_idle_timer
  import bdcr_pkg::*;
#(
  parameter int PRESCALE = 2
) (
  // clock, enable, reset and clear
  input  wire logic      clk,
  input  wire logic      reset_n,
  input  wire logic      ce,
  input  wire logic      clr,
  // timer control
  input  wire logic      idle,
  input  wire bdcr_tmr_t limit,
  // result
  output logic           expired
);

  localparam int PW = $clog2(PRESCALE + 1);

  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  bdcr_tmr_t     tick_reg;
  bdcr_tmr_t     tick_next;
  logic          exp_next;
  wire           tick;
  wire           reached;

  // --------------------------------------------------------------------------
  // prescaler and tick counter
  // --------------------------------------------------------------------------
  assign tick      = (pre_reg == PW'(PRESCALE - 1));
  assign reached   = (tick_reg >= limit);
  assign pre_next  = (clr || !idle || tick) ? '0 : pre_reg + PW'(1);
  assign tick_next = (clr || !idle) ? '0 : ((tick && !reached) ? tick_reg + 4'h1 : tick_reg);
  assign exp_next  = !clr && idle && reached;

  // state update, frozen while ce is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg  <= '0;
      tick_reg <= '0;
      expired  <= 1'b0;
    end else if (ce) begin
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
      expired  <= exp_next;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_timer_busy_drop: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !idle |=> !expired) else $error("idle timer expired while busy");

endmodule
`default_nettype wire

//--- design/bdcr_regs.sv
`include "bdcr_cfg.svh"
`default_nettype none
module bdcr_regs
  import bdcr_pkg::*;
(
  // clock, enable and resets
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    ce,
  input  wire logic                    link_reset_n,
  input  wire logic                    global_reset_pin_n,
  // configuration access port
  input  wire logic                    cfg_wr,
  input  wire logic                    cfg_rd,
  input  wire logic [`BDCR_ADDR_W-1:0] cfg_addr,
  input  wire logic [3:0]              cfg_be,
  input  wire bdcr_word_t              cfg_wdata,
  output bdcr_word_t                   cfg_rdata,
  output logic                         cfg_rvalid,
  // upstream buffer threshold
  input  wire logic [7:0]              cache_line_size_dw,
  input  wire logic [9:0]              up_free_space_dw,
  input  wire logic                    sec_txn_req,
  output bdcr_thr_t                    up_threshold_dw,
  output logic                         sec_txn_accept,
  // mapped register access gate
  input  wire logic                    mmio_cfg_req,
  output logic                         mmio_cfg_grant,
  // link clocking and fast training
  input  wire logic                    shared_clock_config,
  input  wire bdcr_fts_t               n_fts_separate_clk,
  input  wire bdcr_fts_t               n_fts_shared_clk,
  output logic [2:0]                   advertised_l1_exit_latency,
  output bdcr_fts_t                    fts_count,
  // secondary bus reset
  input  wire logic                    secondary_bus_reset_bit,
  output logic                         secondary_reset_out,
  // power state idle timers
  input  wire logic                    link_idle,
  output logic                         l1_entry_req,
  output logic                         standby_entry_req
);

  // --------------------------------------------------------------------------
  // storage and next values
  // --------------------------------------------------------------------------
  logic [`BDCR_UBT_W-1:0]  ubt_reg;
  logic [`BDCR_UBT_W-1:0]  ubt_next;
  logic [`BDCR_DIAG_W-1:0] diag_reg;
  logic [`BDCR_DIAG_W-1:0] diag_next;
  bdcr_word_t              rdata_next;
  bdcr_thr_t               thr_next;
  logic                    accept_next;
  logic [2:0]              lat_next;
  bdcr_fts_t               fts_next;

  // --------------------------------------------------------------------------
  // address decode and write masks
  // --------------------------------------------------------------------------
  wire                     hit_ubt;
  wire                     hit_diag;
  wire                     field_clr;
  wire                     wr_ubt;
  wire                     wr_diag;
  wire [31:0]              be_mask;
  wire [`BDCR_DIAG_W-1:0]  diag_mask;
  wire [`BDCR_UBT_W-1:0]   ubt_mask;

  assign hit_ubt   = (cfg_addr == `BDCR_UBT_OFFSET);
  assign hit_diag  = (cfg_addr == `BDCR_DIAG_OFFSET);
  assign field_clr = !link_reset_n || !global_reset_pin_n;
  assign wr_ubt    = cfg_wr && hit_ubt && cfg_be[0];
  assign wr_diag   = cfg_wr && hit_diag;
  assign be_mask   = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign diag_mask = be_mask[`BDCR_DIAG_W-1:0];
  assign ubt_mask  = `BDCR_UBT_WMASK;

  // --------------------------------------------------------------------------
  // register next values
  // --------------------------------------------------------------------------
  // reserved writable bits are plain storage that resets to zero
  assign ubt_next  = field_clr ? `BDCR_UBT_RESET :
                     wr_ubt ? ((ubt_reg & ~ubt_mask) | (cfg_wdata[`BDCR_UBT_W-1:0] & ubt_mask))
                            : ubt_reg;
  assign diag_next = field_clr ? `BDCR_DIAG_RESET :
                     wr_diag ? ((diag_reg & ~diag_mask)
                                | (cfg_wdata[`BDCR_DIAG_W-1:0] & diag_mask))
                             : diag_reg;

  // --------------------------------------------------------------------------
  // field views
  // --------------------------------------------------------------------------
  wire [1:0] thr_sel;
  wire       thr_en;
  wire       cfg_mem_en;
  wire [2:0] l1_exit_latency_separate_clk;
  wire [2:0] l1_exit_latency_shared_clk;
  wire       secondary_reset_suppress;
  wire [3:0] l1_entry_idle_timer;
  wire [3:0] standby_entry_idle_timer;

  assign thr_sel                      = ubt_reg[`BDCR_UBT_SEL_HI:`BDCR_UBT_SEL_LO];
  assign thr_en                       = ubt_reg[`BDCR_UBT_EN_BIT];
  assign cfg_mem_en                   = ubt_reg[`BDCR_UBT_CFGMEM_BIT];
  assign l1_exit_latency_separate_clk = diag_reg[`BDCR_L1_SEP_HI:`BDCR_L1_SEP_LO];
  assign l1_exit_latency_shared_clk   = diag_reg[`BDCR_L1_SHR_HI:`BDCR_L1_SHR_LO];
  assign secondary_reset_suppress     = diag_reg[`BDCR_SECONDARY_BUS_RESET_BIT_SUP_BIT];
  assign l1_entry_idle_timer          = diag_reg[`BDCR_L1_TMR_HI:`BDCR_L1_TMR_LO];
  assign standby_entry_idle_timer     = diag_reg[`BDCR_L0S_TMR_HI:`BDCR_L0S_TMR_LO];

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  // unmapped offsets and upper bytes of the threshold word read as zero
  assign rdata_next = hit_ubt  ? {24'h000000, ubt_reg} :
                      hit_diag ? {`BDCR_DIAG_UPPER_ZERO, diag_reg} :
                                 32'h00000000;

  // --------------------------------------------------------------------------
  // upstream buffer threshold
  // --------------------------------------------------------------------------
  // a cache line size is taken as valid when it is a nonzero power of two
  wire       cl_valid;
  wire [7:0] cl_dw;
  wire [9:0] cl_ext;

  assign cl_valid = (cache_line_size_dw != 8'h00)
                    && ((cache_line_size_dw & (cache_line_size_dw - 8'h01)) == 8'h00);
  assign cl_dw    = cl_valid ? cache_line_size_dw : `BDCR_CL_DEFAULT_DW;
  assign cl_ext   = {2'h0, cl_dw};

  // free space needed before a transaction is taken
  always_comb begin
    case (thr_sel)
      `BDCR_THR_SEL_CL4:  thr_next = cl_ext + `BDCR_THR_ADD_4;
      `BDCR_THR_SEL_CL8:  thr_next = cl_ext + `BDCR_THR_ADD_8;
      `BDCR_THR_SEL_CL12: thr_next = cl_ext + `BDCR_THR_ADD_12;
      `BDCR_THR_SEL_2CL4: thr_next = {cl_ext[8:0], 1'b0} + `BDCR_THR_ADD_4;
      default:            thr_next = cl_ext + `BDCR_THR_ADD_4;
    endcase
  end

  // decision uses the threshold computed from the current fields
  assign accept_next = sec_txn_req
                       && (!thr_en || (up_free_space_dw >= thr_next));

  // --------------------------------------------------------------------------
  // link clocking selections
  // --------------------------------------------------------------------------
  assign lat_next = shared_clock_config ? l1_exit_latency_separate_clk
                                        : l1_exit_latency_shared_clk;
  assign fts_next = shared_clock_config ? n_fts_shared_clk : n_fts_separate_clk;

  // --------------------------------------------------------------------------
  // registers and registered outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ubt_reg  <= `BDCR_UBT_RESET;
      diag_reg <= `BDCR_DIAG_RESET;
    end else if (ce) begin
      ubt_reg  <= ubt_next;
      diag_reg <= diag_next;
    end
  end

  // read port answers one cycle after the request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else if (ce) begin
      cfg_rdata  <= cfg_rd ? rdata_next : cfg_rdata;
      cfg_rvalid <= cfg_rd;
    end
  end

  // threshold, acceptance and access gate
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_threshold_dw <= 10'h000;
      sec_txn_accept  <= 1'b0;
      mmio_cfg_grant  <= 1'b0;
    end else if (ce) begin
      up_threshold_dw <= thr_next;
      sec_txn_accept  <= accept_next;
      mmio_cfg_grant  <= mmio_cfg_req && cfg_mem_en;
    end
  end

  // latency mirror, training count and secondary reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      advertised_l1_exit_latency <= 3'h0;
      fts_count                  <= 8'h00;
      secondary_reset_out        <= 1'b0;
    end else if (ce) begin
      advertised_l1_exit_latency <= lat_next;
      fts_count                  <= fts_next;
      secondary_reset_out        <= secondary_bus_reset_bit && !secondary_reset_suppress;
    end
  end

  // --------------------------------------------------------------------------
  // idle timers
  // --------------------------------------------------------------------------
  bdcr_idle_timer #(
    .PRESCALE (`BDCR_L1_TICK_CYC)
  ) u_l1_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .clr     (field_clr),
    .idle    (link_idle),
    .limit   (l1_entry_idle_timer),
    .expired (l1_entry_req)
  );

  bdcr_idle_timer #(
    .PRESCALE (`BDCR_L0S_TICK_CYC)
  ) u_standby_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .clr     (field_clr),
    .idle    (link_idle),
    .limit   (standby_entry_idle_timer),
    .expired (standby_entry_req)
  );

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_thr_valid_cl: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !field_clr && !wr_ubt && thr_sel == 2'h2 && cache_line_size_dw == 8'h10
    |=> up_threshold_dw == 10'h01c) else $error("threshold decode wrong");

  a_thr_bad_cl: assert property (@(posedge clk) disable iff (!reset_n)
    ce && thr_sel == 2'h3 && cache_line_size_dw == 8'h0c
    |=> up_threshold_dw == 10'h014) else $error("invalid cache line not 8 DW");

  a_thr_mode_off: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !thr_en && sec_txn_req |=> sec_txn_accept) else $error("refused with mode off");

  a_thr_refuse: assert property (@(posedge clk) disable iff (!reset_n)
    ce && thr_en && sec_txn_req && up_free_space_dw < thr_next
    |=> !sec_txn_accept) else $error("accepted without free space");

  a_mmio_gate_off: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !cfg_mem_en |=> !mmio_cfg_grant) else $error("mapped access while disabled");

  a_ubt_bit0_zero: assert property (@(posedge clk) disable iff (!reset_n)
    $past(ce) && cfg_rvalid && $past(cfg_addr) == `BDCR_UBT_OFFSET
    |-> cfg_rdata[0] == 1'b0) else $error("reserved bit 0 read nonzero");

  a_diag_upper_zero: assert property (@(posedge clk) disable iff (!reset_n)
    $past(ce) && cfg_rvalid && $past(cfg_addr) == `BDCR_DIAG_OFFSET
    |-> cfg_rdata[31:21] == 11'h000) else $error("upper diagnostic bits nonzero");

  a_field_reset: assert property (@(posedge clk) disable iff (!reset_n)
    ce && field_clr |=> diag_reg == `BDCR_DIAG_RESET && ubt_reg == `BDCR_UBT_RESET)
    else $error("fields not restored by reset input");

  a_l1_mirror: assert property (@(posedge clk) disable iff (!reset_n)
    ce && shared_clock_config
    |=> advertised_l1_exit_latency == $past(diag_reg[20:18])) else $error("latency mirror");

  a_l1_mirror_sep: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !shared_clock_config
    |=> advertised_l1_exit_latency == $past(diag_reg[17:15])) else $error("latency mirror");

  a_secondary_bus_reset_bit_masked: assert property (@(posedge clk) disable iff (!reset_n)
    ce && secondary_reset_suppress |=> !secondary_reset_out) else $error("reset not masked");

  a_fts_select: assert property (@(posedge clk) disable iff (!reset_n)
    ce && shared_clock_config |=> fts_count == $past(n_fts_shared_clk))
    else $error("wrong fast training count");

endmodule
`default_nettype wire

//--- testbench/bdcr_host.sv
`include "bdcr_cfg.svh"
`default_nettype none
module bdcr_host
  import bdcr_pkg::*;
(
  // clock
  input  wire logic        clk,
  // configuration access port
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output bdcr_word_t       cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // host side of the configuration port
  // ---------------------------------------------------------------------
  initial begin
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // idle bus shows inverted leftovers so stale values never pass for a request
  task automatic park();
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = ~cfg_addr;
    cfg_be    = ~cfg_be;
    cfg_wdata = ~cfg_wdata;
  endtask

  // one write, reserved writable bits forced to zero as software must
  task automatic do_write(input logic [7:0] a, input logic [3:0] be, input bdcr_word_t d);
    bdcr_word_t v;
    v = d;
    if (a == `BDCR_UBT_OFFSET) v[1] = 1'b0;
    if (a == `BDCR_DIAG_OFFSET) begin
      v[14:11] = 4'h0;
      v[1:0]   = 2'h0;
    end
    @(posedge clk);
    #1;
    cfg_wr    = 1'b1;
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = v;
    @(posedge clk);
    #1;
    park();
  endtask

  // one read strobe; data is collected by the watcher
  task automatic do_read(input logic [7:0] a);
    @(posedge clk);
    #1;
    cfg_rd   = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #1;
    park();
  endtask
endmodule
`default_nettype wire

//--- testbench/bdcr_regs_test.sv
`include "bdcr_cfg.svh"
`default_nettype none
module bdcr_regs_test
  import bdcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic clk, reset_n, ce, link_reset_n, global_reset_pin_n;
  logic cfg_wr, cfg_rd, cfg_rvalid;
  logic [7:0] cfg_addr, cache_line_size_dw;
  logic [3:0] cfg_be;
  bdcr_word_t cfg_wdata, cfg_rdata;
  logic [9:0] up_free_space_dw;
  bdcr_thr_t up_threshold_dw;
  logic sec_txn_req, sec_txn_accept, mmio_cfg_req, mmio_cfg_grant, shared_clock_config;
  bdcr_fts_t n_fts_separate_clk, n_fts_shared_clk, fts_count;
  logic [2:0] advertised_l1_exit_latency;
  logic secondary_bus_reset_bit, secondary_reset_out, link_idle, l1_entry_req, standby_entry_req;
  int n_errors, compares, n_cyc, n_l1, n_l0s;
  logic [31:0] seed;
  logic [31:0] exp_q[$];
  logic [9:0] t;

  bdcr_host host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  bdcr_regs dut (.clk(clk), .reset_n(reset_n), .ce(ce), .link_reset_n(link_reset_n),
    .global_reset_pin_n(global_reset_pin_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .cache_line_size_dw(cache_line_size_dw),
    .up_free_space_dw(up_free_space_dw), .sec_txn_req(sec_txn_req),
    .up_threshold_dw(up_threshold_dw), .sec_txn_accept(sec_txn_accept),
    .mmio_cfg_req(mmio_cfg_req), .mmio_cfg_grant(mmio_cfg_grant),
    .shared_clock_config(shared_clock_config), .n_fts_separate_clk(n_fts_separate_clk),
    .n_fts_shared_clk(n_fts_shared_clk), .advertised_l1_exit_latency(advertised_l1_exit_latency),
    .fts_count(fts_count), .secondary_bus_reset_bit(secondary_bus_reset_bit),
    .secondary_reset_out(secondary_reset_out), .link_idle(link_idle),
    .l1_entry_req(l1_entry_req), .standby_entry_req(standby_entry_req));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // note the expected read data, then issue the read
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    host.do_read(a);
  endtask

  // required free space from the select code and the cache line size
  function automatic logic [9:0] thr(input logic [7:0] cl, input logic [1:0] sel);
    logic [9:0] c;
    c = (cl != 8'h00 && (cl & (cl - 8'h01)) == 8'h00) ? {2'h0, cl} : 10'h008;
    case (sel)
      2'h0: thr = c + 10'h004;
      2'h1: thr = c + 10'h008;
      2'h2: thr = c + 10'h00c;
      default: thr = (c << 1) + 10'h004;
    endcase
  endfunction

  // watcher: every read answer is matched with the oldest note, or with all ones when no note is left
  always @(negedge clk) begin
    if (cfg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(cfg_rdata, 32'hffff_ffff);
      else check(cfg_rdata, exp_q.pop_front());
    end
  end

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    seed = 32'h1522;
    {reset_n, link_reset_n, global_reset_pin_n} = 3'b011;
    {sec_txn_req, mmio_cfg_req, shared_clock_config, secondary_bus_reset_bit} = 4'h0;
    link_idle = 1'b0;
    ce = 1'b1;
    cache_line_size_dw = 8'h10;
    up_free_space_dw = 10'h000;
    n_fts_separate_clk = 8'($random(seed));
    n_fts_shared_clk = 8'($random(seed));
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rd(`BDCR_UBT_OFFSET, 32'h0000_0000);
    rd(`BDCR_DIAG_OFFSET, 32'h0012_0108);
    host.do_write(`BDCR_UBT_OFFSET, 4'hf, 32'hffff_ffff);
    rd(`BDCR_UBT_OFFSET, 32'h0000_003c);
    host.do_write(`BDCR_DIAG_OFFSET, 4'hf, 32'hffff_ffff);
    rd(`BDCR_DIAG_OFFSET, 32'h001f_87fc);
    host.do_write(8'hc8, 4'hf, 32'hffff_ffff);
    rd(8'hc8, 32'h0000_0000);
    link_reset_n = 1'b0;
    @(posedge clk);
    #1;
    link_reset_n = 1'b1;
    rd(`BDCR_UBT_OFFSET, 32'h0000_0000);
    rd(`BDCR_DIAG_OFFSET, 32'h0012_0108);
    // threshold select, enable and gate, with random sizes
    for (int en = 0; en < 2; en++) begin
      for (int s = 0; s < 4; s++) begin
        host.do_write(`BDCR_UBT_OFFSET, 4'h1, {26'h0, s[1:0], en[0], 3'h4});
        for (int j = 0; j < 3; j++) begin
          // first size is invalid, second a fixed valid one, third random
          cache_line_size_dw = (j == 0) ? 8'h0c : (j == 1) ? 8'h10
                             : 8'(8'h01 << ($random(seed) & 7));
          up_free_space_dw = 10'($random(seed));
          if (j == 2) up_free_space_dw = thr(cache_line_size_dw, s[1:0]);
          sec_txn_req = 1'b1;
          mmio_cfg_req = 1'b1;
          t = thr(cache_line_size_dw, s[1:0]);
          @(posedge clk);
          #1;
          check({22'h0, up_threshold_dw}, {22'h0, t});
          check({31'h0, sec_txn_accept}, {31'h0, !en[0] || up_free_space_dw >= t});
          check({31'h0, mmio_cfg_grant}, 32'h0000_0001);
        end
      end
    end
    // latency mirror, training count and reset suppress
    host.do_write(`BDCR_DIAG_OFFSET, 4'hf, 32'h000e_8508);
    rd(`BDCR_DIAG_OFFSET, 32'h000e_8508);
    secondary_bus_reset_bit = 1'b1;
    for (int sh = 0; sh < 2; sh++) begin
      shared_clock_config = sh[0];
      @(posedge clk);
      #1;
      check({29'h0, advertised_l1_exit_latency}, sh ? 32'h3 : 32'h5);
      check({24'h0, fts_count}, {24'h0, sh ? n_fts_shared_clk : n_fts_separate_clk});
      check({31'h0, secondary_reset_out}, 32'h0000_0000);
    end
    // clock enable low freezes the latency mirror
    ce = 1'b0;
    shared_clock_config = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({29'h0, advertised_l1_exit_latency}, 32'h0000_0003);
    ce = 1'b1;
    @(posedge clk);
    #1;
    check({29'h0, advertised_l1_exit_latency}, 32'h0000_0005);
    // software puts the diagnostic fields back to their defaults
    host.do_write(`BDCR_DIAG_OFFSET, 4'hf, 32'h0012_0108);
    @(posedge clk);
    #1;
    check({31'h0, secondary_reset_out}, 32'h0000_0001);
    // global reset pin restores defaults and closes the access gate
    global_reset_pin_n = 1'b0;
    @(posedge clk);
    #1;
    global_reset_pin_n = 1'b1;
    rd(`BDCR_UBT_OFFSET, 32'h0000_0000);
    @(posedge clk);
    #1;
    check({31'h0, mmio_cfg_grant}, 32'h0000_0000);
    // idle timers with default fields 4 and 2
    n_l1 = 0;
    n_l0s = 0;
    link_idle = 1'b1;
    for (int i = 1; i <= 300; i++) begin
      @(posedge clk);
      #1;
      if (n_l0s == 0 && standby_entry_req === 1'b1) n_l0s = i;
      if (n_l1 == 0 && l1_entry_req === 1'b1) n_l1 = i;
    end
    check({31'h0, n_l0s >= 4 && n_l0s <= 7}, 32'h0000_0001);
    check({31'h0, n_l1 >= 158 && n_l1 <= 211}, 32'h0000_0001);
    link_idle = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({30'h0, l1_entry_req, standby_entry_req}, 32'h0000_0000);
    repeat (3) @(posedge clk);
    check(exp_q.size(), 32'h0000_0000);
    end_sim();
  end
endmodule
`default_nettype wire
